// File: hdl/literal_return_rotate_exec.sv
// Purpose: decode and execute the literal, return, rotate, subtract, swap, direction group
// Assumes: instr_valid pulses once per instruction cycle; reg_rd_data is the addressed register
// Notes: other opcodes are ignored; busy holds off the fetch during a return's second cycle
`include "lrre_consts.svh"
module literal_return_rotate_exec
  import lrre_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  input  wire logic [7:0]  reg_rd_data,
  input  wire logic [12:0] stack_top,
  output logic      [7:0]  accumulator,
  output logic      [2:0]  status_flags,
  output logic             global_irq_enable,
  output logic             stack_pop,
  output logic             pc_load,
  output logic      [12:0] pc_value,
  output logic             busy,
  output logic             reg_wr_en,
  output logic      [6:0]  reg_wr_addr,
  output logic      [7:0]  reg_wr_data,
  output logic             dir_wr_en,
  output logic      [2:0]  dir_wr_sel,
  output logic      [7:0]  dir_wr_data
);
  // decoding is shared by the execute step and the flag update
  function automatic lrre_op_t decode(input logic [13:0] w);
    lrre_op_t o;
    o = LRRE_NONE;
    if (w[13:8] == `LRRE_OP_IOR_LIT)                  o = LRRE_IOR;
    else if (w[13:10] == `LRRE_OP_MOV_LIT)            o = LRRE_MOV;
    else if (w[13:10] == `LRRE_OP_RET_LIT)            o = LRRE_RETLIT;
    else if (w == `LRRE_ENC_RET_IRQ)                  o = LRRE_RETFI;
    else if (w == `LRRE_ENC_RET_SUB)                  o = LRRE_RETSUB;
    else if (w[13:3] == `LRRE_ENC_DIR_HI && w[2:0] >= `LRRE_DIR_MIN)
      o = LRRE_DIR;
    else if (w[13:8] == `LRRE_OP_ROT_LEFT)            o = LRRE_ROT;
    else if (w[13:8] == `LRRE_OP_SUB_ACC)             o = LRRE_SUB;
    else if (w[13:8] == `LRRE_OP_NIB_SWAP)            o = LRRE_SWAP;
    return o;
  endfunction : decode

  // the three returns share the pop and the two-cycle sequencing
  function automatic logic is_return(input lrre_op_t o);
    return (o == LRRE_RETFI) || (o == LRRE_RETSUB) || (o == LRRE_RETLIT);
  endfunction : is_return

  // register-operand group: result goes through the alu and the destination bit
  function automatic logic is_reg_op(input lrre_op_t o);
    return (o == LRRE_ROT) || (o == LRRE_SUB) || (o == LRRE_SWAP);
  endfunction : is_reg_op

  lrre_op_t    op;
  lrre_op_t    exec_op;
  lrre_state_t state;
  lrre_state_t next_state;
  logic [7:0]  alu_result;
  logic        alu_carry;
  logic        alu_half;
  logic [7:0]  ior_value;
  logic [7:0]  next_accumulator;
  logic [7:0]  next_reg_wr_data;
  logic [7:0]  next_dir_wr_data;
  logic [2:0]  next_status_flags;
  logic [2:0]  next_dir_wr_sel;
  logic        next_global_irq_enable;
  logic        next_stack_pop;
  logic        next_pc_load;
  logic        next_busy;
  logic        next_reg_wr_en;
  logic        next_dir_wr_en;
  logic [6:0]  next_reg_wr_addr;
  logic [12:0] next_pc_value;
  logic        to_reg;

  assign op        = instr_valid ? decode(instr) : LRRE_NONE;
  // an instruction offered in a return's second cycle is dropped, not queued
  assign exec_op   = (state == LRRE_ST_IDLE) ? op : LRRE_NONE;
  assign ior_value = accumulator | instr[7:0];
  assign to_reg    = instr[`LRRE_DEST_BIT];

  // the alu sees the raw decode; its outputs only matter when exec_op lets them through
  lrre_alu u_alu (
    .op        (op),
    .reg_val   (reg_rd_data),
    .acc_val   (accumulator),
    .carry_in  (status_flags[`LRRE_FLAG_C]),
    .result    (alu_result),
    .carry_out (alu_carry),
    .half_out  (alu_half)
  );

  // sequencing group: the return pop, the pc reload and the hold-off cycle
  always_comb
  begin
    next_state             = LRRE_ST_IDLE;
    next_global_irq_enable = global_irq_enable;
    next_stack_pop         = 1'b0;
    next_pc_load           = 1'b0;
    next_pc_value          = pc_value;
    next_busy              = 1'b0;
    case (state)
      LRRE_ST_IDLE:
      begin
        if (is_return(exec_op))
        begin
          next_stack_pop = 1'b1;
          next_pc_load   = 1'b1;
          next_pc_value  = stack_top;
          next_busy      = 1'b1;
          next_state     = LRRE_ST_SECOND;
        end
        if (exec_op == LRRE_RETFI)
          next_global_irq_enable = 1'b1;
      end
      LRRE_ST_SECOND: next_state = LRRE_ST_IDLE;      // second cycle of a return
      default:        next_state = LRRE_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state             <= LRRE_ST_IDLE;
      global_irq_enable <= 1'b0;
      stack_pop         <= 1'b0;
      pc_load           <= 1'b0;
      pc_value          <= 13'h0000;
      busy              <= 1'b0;
    end
    else
    begin
      state             <= next_state;
      global_irq_enable <= next_global_irq_enable;
      stack_pop         <= next_stack_pop;
      pc_load           <= next_pc_load;
      pc_value          <= next_pc_value;
      busy              <= next_busy;
    end
  end

  // data group: accumulator and status flags
  always_comb
  begin
    next_accumulator  = accumulator;
    next_status_flags = status_flags;
    case (exec_op)
      LRRE_IOR:
      begin
        next_accumulator                = ior_value;
        next_status_flags[`LRRE_FLAG_Z] = (ior_value == 8'h00);
      end
      LRRE_MOV:    next_accumulator = instr[7:0];
      LRRE_RETLIT: next_accumulator = instr[7:0];
      default:
      begin
        if (is_reg_op(exec_op))
        begin
          if (!to_reg)
            next_accumulator = alu_result;
          if (exec_op != LRRE_SWAP)
            next_status_flags[`LRRE_FLAG_C] = alu_carry;
          if (exec_op == LRRE_SUB)
          begin
            next_status_flags[`LRRE_FLAG_HC] = alu_half;
            next_status_flags[`LRRE_FLAG_Z]  = (alu_result == 8'h00);
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      accumulator  <= 8'h00;
      status_flags <= 3'h0;
    end
    else
    begin
      accumulator  <= next_accumulator;
      status_flags <= next_status_flags;
    end
  end

  // write-port group; address and data are registered every cycle and only the
  // enables qualify them, which keeps the muxes off the register-file timing path
  always_comb
  begin
    next_reg_wr_en   = 1'b0;
    next_reg_wr_addr = instr[6:0];
    next_reg_wr_data = alu_result;
    next_dir_wr_en   = 1'b0;
    next_dir_wr_sel  = instr[2:0];
    next_dir_wr_data = accumulator;
    if (is_reg_op(exec_op) && to_reg)
      next_reg_wr_en = 1'b1;
    if (exec_op == LRRE_DIR)
      next_dir_wr_en = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_wr_en   <= 1'b0;
      reg_wr_addr <= 7'h00;
      reg_wr_data <= 8'h00;
      dir_wr_en   <= 1'b0;
      dir_wr_sel  <= 3'h0;
      dir_wr_data <= 8'h00;
    end
    else
    begin
      reg_wr_en   <= next_reg_wr_en;
      reg_wr_addr <= next_reg_wr_addr;
      reg_wr_data <= next_reg_wr_data;
      dir_wr_en   <= next_dir_wr_en;
      dir_wr_sel  <= next_dir_wr_sel;
      dir_wr_data <= next_dir_wr_data;
    end
  end
endmodule : literal_return_rotate_exec

// File: hdl/lrre_consts.svh
// Purpose: constants for the literal/return/rotate execute block
// Assumes: 14-bit instruction word, 8-bit data path, 13-bit program counter
// Notes: offsets of nothing; opcodes, the destination bit, the lowest direction register, flag positions and cycle counts only
// Overview of operation
// - or-literal (11 1000 kkkkkkkk) ORs the literal into the accumulator and updates only zero.
// - return-from-interrupt (00 0000 0000 1001) pops stack top into the pc and sets irq enable.
// - every return pops the stack, moving the top entry into the pc and discarding it.
// - the three returns take two instruction cycles, all others in this group take one.
// - return-with-literal (11 01xx kkkkkkkk) loads the literal and reloads pc, no flags.
// - rotate-left (00 1101) shifts left, old carry into bit 0, old bit 7 into carry.
// - subtract (00 0010) computes register minus accumulator, updating carry, half carry, zero.
// - after subtract carry is 1 for zero or positive result and 0 when a borrow occurred.
// - destination bit 0 sends the result to the accumulator, 1 back to the register.
// - port direction load (00 0000 0110 0fff) copies accumulator to direction reg 5..7.
`ifndef LRRE_CONSTS_SVH
`define LRRE_CONSTS_SVH
`define LRRE_OP_IOR_LIT   6'h38
`define LRRE_OP_MOV_LIT   4'hC
`define LRRE_OP_RET_LIT   4'hD
`define LRRE_OP_ROT_LEFT  6'h0D
`define LRRE_OP_SUB_ACC   6'h02
`define LRRE_OP_NIB_SWAP  6'h0E
`define LRRE_ENC_RET_IRQ  14'h0009
`define LRRE_ENC_RET_SUB  14'h0008
`define LRRE_ENC_DIR_HI   11'h00C
`define LRRE_DIR_MIN      3'h5
`define LRRE_DEST_BIT     7
`define LRRE_FLAG_C       0
`define LRRE_FLAG_HC      1
`define LRRE_FLAG_Z       2
`define LRRE_RET_CYCLES   2'h2
`endif

// File: hdl/lrre_pkg.sv
// Purpose: types shared by the execute block
// Assumes: nothing beyond the constants header
// Notes: states gray coded along idle -> second cycle
package lrre_pkg;
  typedef enum logic [0:0] {
    LRRE_ST_IDLE   = 1'b0,
    LRRE_ST_SECOND = 1'b1
  } lrre_state_t;
  typedef enum logic [3:0] {
    LRRE_NONE, LRRE_IOR, LRRE_MOV, LRRE_RETFI, LRRE_RETSUB, LRRE_RETLIT,
    LRRE_ROT, LRRE_SUB, LRRE_SWAP, LRRE_DIR
  } lrre_op_t;
endpackage : lrre_pkg

// File: hdl/lrre_alu.sv
// Purpose: combinational arithmetic for the register-operand instructions
// Assumes: operands valid in the same cycle
// Notes: no state
`include "lrre_consts.svh"
module lrre_alu
  import lrre_pkg::*;
(
  input  wire lrre_op_t   op,
  input  wire logic [7:0] reg_val,
  input  wire logic [7:0] acc_val,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic            carry_out,
  output logic            half_out
);
  logic [8:0] diff;
  logic [4:0] low_diff;
  always_comb
  begin
    diff      = {1'b0, reg_val} + {1'b0, ~acc_val} + 9'h001;
    low_diff  = {1'b0, reg_val[3:0]} + {1'b0, ~acc_val[3:0]} + 5'h01;
    result    = 8'h00;
    carry_out = carry_in;
    half_out  = 1'b0;
    case (op)
      LRRE_ROT:
      begin
        result    = {reg_val[6:0], carry_in};
        carry_out = reg_val[7];
      end
      LRRE_SUB:
      begin
        result    = diff[7:0];
        carry_out = diff[8];                    // no borrow reads as 1
        half_out  = low_diff[4];
      end
      LRRE_SWAP: result = {reg_val[3:0], reg_val[7:4]};
      default:   result = 8'h00;
    endcase
  end
endmodule : lrre_alu

// File: verification/lrre_asserts.sv
// Purpose: port-level checks of the execute block
// Assumes: one clock, reset_n asynchronous active low
// Notes: results are due one edge after the taking edge
module lrre_asserts (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        instr_valid,
  input wire logic [13:0] instr,
  input wire logic [7:0]  reg_rd_data,
  input wire logic [12:0] stack_top,
  input wire logic [7:0]  accumulator,
  input wire logic [2:0]  status_flags,
  input wire logic        global_irq_enable,
  input wire logic        stack_pop,
  input wire logic        pc_load,
  input wire logic [12:0] pc_value,
  input wire logic        busy,
  input wire logic        reg_wr_en,
  input wire logic [6:0]  reg_wr_addr,
  input wire logic [7:0]  reg_wr_data,
  input wire logic        dir_wr_en,
  input wire logic [2:0]  dir_wr_sel,
  input wire logic [7:0]  dir_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  wire take = instr_valid && !busy;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ior_acc_a:
    assert property (take && instr[13:8] == 6'h38 |=> accumulator == ($past(accumulator)
      | $past(instr[7:0])) && status_flags[2] == (accumulator == 8'h00)
      && status_flags[1:0] == $past(status_flags[1:0])) else $error("or literal wrong");
  mov_lit_a:
    assert property (take && instr[13:10] == 4'hC |=> accumulator == $past(instr[7:0])
      && $stable(status_flags)) else $error("move literal wrong");
  ret_pop_a:
    assert property (take && instr[13:1] == 13'h0004 |=> stack_pop && pc_load
      && pc_value == $past(stack_top)) else $error("return pop wrong");
  ret_two_a:
    assert property (take && (instr[13:1] == 13'h0004 || instr[13:10] == 4'hD)
      |=> busy ##1 !busy && !stack_pop) else $error("return length wrong");
  rot_c_a:
    assert property (take && instr[13:7] == 7'h1A |=> accumulator == {$past(reg_rd_data[6:0]),
      $past(status_flags[0])} && status_flags[0] == $past(reg_rd_data[7]))
      else $error("rotate wrong");
  sub_c_a:
    assert property (take && instr[13:8] == 6'h02 |=> status_flags[0] == ($past(reg_rd_data)
      >= $past(accumulator))) else $error("subtract carry wrong");
  swap_wr_a:
    assert property (take && instr[13:7] == 7'h1D |=> reg_wr_en && reg_wr_addr
      == $past(instr[6:0]) && reg_wr_data == {$past(reg_rd_data[3:0]),
      $past(reg_rd_data[7:4])}) else $error("swap wrong");
  dir_wr_a:
    assert property (take && instr[13:3] == 11'h00C && instr[2:0] >= 3'h5 |=> dir_wr_en
      && dir_wr_sel == $past(instr[2:0]) && dir_wr_data == $past(accumulator))
      else $error("direction load wrong");
  irq_set_a:
    assert property (take && instr == 14'h0009 |=> global_irq_enable)
      else $error("interrupt return left enable clear");
  ret_lit_a:
    assert property (take && instr[13:10] == 4'hD |=> accumulator == $past(instr[7:0])
      && stack_pop && pc_value == $past(stack_top) && $stable(status_flags))
      else $error("literal return wrong");
  ret_keep_a:
    assert property (take && instr == 14'h0008 |=> $stable(global_irq_enable)
      && $stable(status_flags)) else $error("subroutine return changed state");
  busy_drop_a:
    assert property (busy && instr_valid |=> !stack_pop && !reg_wr_en && !dir_wr_en
      && $stable(accumulator)) else $error("instruction taken while busy");
endmodule : lrre_asserts

// File: verification/lrre_partner.sv
// Purpose: data register file in front of the execute block
// Assumes: reads answer in the cycle of the instruction
// Notes: fresh cells read as address xor A5 so results are predictable
module lrre_partner (
  input  wire logic       ref_clk,
  input  wire logic [6:0] rd_addr,
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [128];
  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i) ^ 8'hA5;
  end
  always @(posedge ref_clk)
    if (wr_en)
      mem[wr_addr] <= wr_data;
  assign rd_data = mem[rd_addr];
endmodule : lrre_partner

// File: verification/literal_return_rotate_exec_bench.sv
// Purpose: directed bench for the execute block
// Assumes: inputs change at the falling edge
// Notes: a write followed at once by a read of that cell is avoided
module literal_return_rotate_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0, reset_n = 0, instr_valid = 0;
  logic [13:0] instr = 14'h0000;
  logic [12:0] stack_top = 13'h0000, pc_value;
  logic [7:0]  reg_rd_data, accumulator, reg_wr_data, dir_wr_data;
  logic [2:0]  status_flags, dir_wr_sel;
  logic [6:0]  reg_wr_addr;
  logic        global_irq_enable, stack_pop, pc_load, busy, reg_wr_en, dir_wr_en;
  int          n_mismatch = 0, check_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  literal_return_rotate_exec dut_u (
    .ref_clk           (ref_clk),
    .reset_n           (reset_n),
    .instr_valid       (instr_valid),
    .instr             (instr),
    .reg_rd_data       (reg_rd_data),
    .stack_top         (stack_top),
    .accumulator       (accumulator),
    .status_flags      (status_flags),
    .global_irq_enable (global_irq_enable),
    .stack_pop         (stack_pop),
    .pc_load           (pc_load),
    .pc_value          (pc_value),
    .busy              (busy),
    .reg_wr_en         (reg_wr_en),
    .reg_wr_addr       (reg_wr_addr),
    .reg_wr_data       (reg_wr_data),
    .dir_wr_en         (dir_wr_en),
    .dir_wr_sel        (dir_wr_sel),
    .dir_wr_data       (dir_wr_data)
  );
  lrre_partner mem_u (.ref_clk(ref_clk), .rd_addr(instr[6:0]), .wr_en(reg_wr_en),
    .wr_addr(reg_wr_addr), .wr_data(reg_wr_data), .rd_data(reg_rd_data));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic ex(input logic [13:0] op, input logic [12:0] stk = 13'h0000);
    instr_valid = 1'b1;
    instr = op;
    stack_top = stk;
    @(negedge ref_clk);
  endtask : ex
  task automatic idle;
    instr_valid = 1'b0;
    @(negedge ref_clk);
  endtask : idle
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic t_lit;
    ex(14'h33A5);
    chk(accumulator, 8'hA5);
    ex(14'h385A);
    chk(accumulator, 8'hFF);
    ex(14'h3000);
    ex(14'h3800);
    chk(status_flags, 3'h4);
    $display("literal test done");
  endtask : t_lit
  task automatic t_sub;
    ex(14'h3002);
    ex(14'h0287);
    chk({reg_wr_en, reg_wr_addr}, 8'h87);
    chk(reg_wr_data, 8'hA0);
    chk(status_flags, 3'h3);
    ex(14'h30B5);
    ex(14'h0210);
    chk(status_flags, 3'h7);
    ex(14'h30B6);
    ex(14'h0210);
    chk({reg_wr_en, accumulator}, 9'h0FF);
    chk(status_flags, 3'h0);
    $display("subtract test done");
  endtask : t_sub
  task automatic t_rot_swap;
    ex(14'h0D01);
    chk({status_flags, accumulator}, 11'h148);
    ex(14'h0D81);
    chk({reg_wr_en, reg_wr_data}, 9'h149);
    ex(14'h0E83);
    chk({reg_wr_en, reg_wr_data}, 9'h16A);
    idle();
    ex(14'h0E03);
    chk({status_flags, accumulator}, 11'h1A6);
    $display("rotate and swap test done");
  endtask : t_rot_swap
  task automatic t_dir;
    ex(14'h303C);
    for (int i = 3; i < 8; i++)
    begin
      ex(14'h0060 | 14'(i));
      if (i >= 5)
        chk({dir_wr_en, dir_wr_sel}, 16'(8 + i));
      else
        chk(dir_wr_en, 1'b0);
    end
    chk(dir_wr_data, 8'h3C);
    $display("direction test done");
  endtask : t_dir
  task automatic t_ret;
    idle();
    ex(14'h0008, 13'h1234);
    chk({stack_pop, pc_load, busy, global_irq_enable}, 4'hE);
    chk(pc_value, 13'h1234);
    ex(14'h3055);
    chk({stack_pop, busy, accumulator}, 10'h03C);
    idle();
    ex(14'h0009, 13'h0ABC);
    chk({global_irq_enable, pc_value}, 14'h2ABC);
    idle();
    ex(14'h3477, 13'h0321);
    chk({stack_pop, pc_value}, 14'h2321);
    chk({status_flags, accumulator}, 11'h177);
    idle();
    $display("return test done");
  endtask : t_ret
  initial
  begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    t_lit();
    t_sub();
    t_rot_swap();
    t_dir();
    t_ret();
    finish_test();
  end
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end
endmodule : literal_return_rotate_exec_bench
bind literal_return_rotate_exec lrre_asserts chk_u (
  .ref_clk           (ref_clk),
  .reset_n           (reset_n),
  .instr_valid       (instr_valid),
  .instr             (instr),
  .reg_rd_data       (reg_rd_data),
  .stack_top         (stack_top),
  .accumulator       (accumulator),
  .status_flags      (status_flags),
  .global_irq_enable (global_irq_enable),
  .stack_pop         (stack_pop),
  .pc_load           (pc_load),
  .pc_value          (pc_value),
  .busy              (busy),
  .reg_wr_en         (reg_wr_en),
  .reg_wr_addr       (reg_wr_addr),
  .reg_wr_data       (reg_wr_data),
  .dir_wr_en         (dir_wr_en),
  .dir_wr_sel        (dir_wr_sel),
  .dir_wr_data       (dir_wr_data)
);
